// ---- hdl/close_onto_fault_logic_pkg.sv ----
// Constants, types and the register map of the close-onto-fault trip block.
// Assumes a single 20 MHz system clock and an APB register port.
package close_onto_fault_logic_pkg;

  // Timebase
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

  // Operation codes and monitored status codes
  localparam logic [2:0] OP_ENABLE = 3'h1;
  localparam logic [2:0] OP_DISABLE = 3'h5;
  localparam logic [2:0] STAT_ENABLED = 3'h1;
  localparam logic [2:0] STAT_BLOCKED = 3'h2;
  localparam logic [2:0] STAT_DISABLED = 3'h5;

  // Setting limits and reset values, in ms
  localparam logic [15:0] SETTING_MAX = 16'hEA60;
  localparam logic [15:0] ARM_DEFAULT = 16'h03E8;
  localparam logic [15:0] DELAY_DEFAULT = 16'h0000;

  // Register byte offsets
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_ARM = 12'h004;
  localparam logic [11:0] ADDR_DELAY = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00C;
  localparam logic [11:0] ADDR_MASK = 12'h010;
  localparam logic [11:0] ADDR_STATE = 12'h014;

  // Field positions
  localparam int unsigned CTRL_OP_LSB = 0;
  localparam int unsigned STATE_CODE_LSB = 0;
  localparam int unsigned STATE_WIN_BIT = 4;
  localparam int unsigned STATE_TRIP_BIT = 5;
  localparam int unsigned STATE_IN_LSB = 8;

  // Event bits of the status and mask registers
  localparam int unsigned EV_TRIP = 0;
  localparam int unsigned EV_ARM = 1;
  localparam int unsigned EV_BLOCK = 2;
  localparam int unsigned EV_WIDTH = 3;

  // Input vector positions
  localparam int unsigned IN_NOW = 0;
  localparam int unsigned IN_DLY = 1;
  localparam int unsigned IN_CLOSE = 2;
  localparam int unsigned IN_BLOCK = 3;

  // Timer indices
  localparam int unsigned TMR_ARM = 0;
  localparam int unsigned TMR_DLY = 1;

  typedef enum logic [1:0] {
    WIN_IDLE,
    WIN_CLOSE,
    WIN_HOLD
  } window_state_type;

endpackage

// ---- hdl/close_onto_fault_logic_ms_timer.sv ----
// Millisecond timer: counts ticks while running, clears on request.
// Assumes a one-cycle ms tick from the system clock domain.
`timescale 1ns/1ps
module close_onto_fault_logic_ms_timer (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  // Control
  input wire logic i_tick,
  input wire logic i_run,
  input wire logic i_clear,
  input wire logic [15:0] i_setting,
  // Result
  output logic [15:0] o_count,
  output logic o_elapsed
);

  typedef struct packed {
    logic [15:0] count;
  } timer_state_type;

  timer_state_type t_reg;
  timer_state_type t_next;

  always_comb begin
    t_next = t_reg;
    if (i_clear) begin
      t_next.count = 16'h0000;
    end else if (i_run && i_tick && t_reg.count != 16'hFFFF) begin
      t_next.count = t_reg.count + 16'h0001;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      t_reg <= '0;
    end else begin
      t_reg <= t_next;
    end
  end

  assign o_count = t_reg.count;
  assign o_elapsed = t_reg.count >= i_setting;

endmodule

// ---- hdl/close_onto_fault_logic.sv ----
// Close-onto-fault trip logic with APB registers and a level interrupt.
// Assumes pickups, close command and block arrive as asynchronous pins.
//
// How it works
// - The operation code enables the function at 1 (reset value) and disables it at 5.
// - The arming window opens as soon as the close command is seen active.
// - After the close command falls the window holds until the arm time runs out.
// - The arm time is set in ms from 0 to 60000, default 1000, larger writes clamp.
// - The trip output rises whenever a fault indication meets an open window.
// - With the window open an immediate pickup trips with no added delay.
// - A delayed pickup counts only once held for the delay setting, 0 to 60000 ms, default 0.
// - Blocking forces the trip low and clears all timers and the window.
// - All four inputs read as false out of reset and until seen high.
// - Timing runs on a 1 ms tick, so the error stays well below 20 ms.
`timescale 1ns/1ps
module close_onto_fault_logic #(
  parameter int unsigned TICK_CYCLES = close_onto_fault_logic_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  // Protection inputs
  input wire logic i_fault_pickup_now,
  input wire logic i_fault_pickup_delayed,
  input wire logic i_breaker_close_command,
  input wire logic i_block,
  // Trip output
  output logic o_fault_clear_out,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Interrupt
  output logic o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [3:0] in_meta;
    logic [3:0] in_sync;
    close_onto_fault_logic_pkg::window_state_type win;
    logic [14:0] tick_cnt;
    logic tick;
    logic blk_prev;
    logic trip;
    logic [2:0] op;
    logic [15:0] arm_set;
    logic [15:0] dly_set;
    logic [close_onto_fault_logic_pkg::EV_WIDTH-1:0] ev;
    logic [close_onto_fault_logic_pkg::EV_WIDTH-1:0] mask;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } core_state_type;

  core_state_type s_reg;
  core_state_type s_next;

  logic [1:0] tmr_run;
  logic [1:0] tmr_clear;
  logic [1:0] tmr_elapsed;
  logic [15:0] tmr_setting [2];
  logic [15:0] tmr_count [2];

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  function automatic logic addr_mapped(input logic [11:0] addr);
    addr_mapped = addr == close_onto_fault_logic_pkg::ADDR_CTRL || addr == close_onto_fault_logic_pkg::ADDR_ARM ||
                  addr == close_onto_fault_logic_pkg::ADDR_DELAY || addr == close_onto_fault_logic_pkg::ADDR_STATUS ||
                  addr == close_onto_fault_logic_pkg::ADDR_MASK || addr == close_onto_fault_logic_pkg::ADDR_STATE;
  endfunction

  function automatic logic [2:0] status_code(input logic [2:0] op, input logic blk);
    if (op != close_onto_fault_logic_pkg::OP_ENABLE) begin
      status_code = close_onto_fault_logic_pkg::STAT_DISABLED;
    end else if (blk) begin
      status_code = close_onto_fault_logic_pkg::STAT_BLOCKED;
    end else begin
      status_code = close_onto_fault_logic_pkg::STAT_ENABLED;
    end
  endfunction

  function automatic logic [15:0] clamp_setting(input logic [15:0] value);
    clamp_setting = (value > close_onto_fault_logic_pkg::SETTING_MAX) ? close_onto_fault_logic_pkg::SETTING_MAX : value;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Timers

  generate
    for (genvar g = 0; g < 2; g++) begin : g_timer
      close_onto_fault_logic_ms_timer u_timer (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .i_tick(s_reg.tick),
        .i_run(tmr_run[g]),
        .i_clear(tmr_clear[g]),
        .i_setting(tmr_setting[g]),
        .o_count(tmr_count[g]),
        .o_elapsed(tmr_elapsed[g])
      );
    end
  endgenerate

  assign tmr_setting[close_onto_fault_logic_pkg::TMR_ARM] = s_reg.arm_set;
  assign tmr_setting[close_onto_fault_logic_pkg::TMR_DLY] = s_reg.dly_set;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  logic enabled;
  logic blocked;
  logic live;
  logic close_cmd;
  logic pick_now;
  logic pick_dly;
  logic dly_ready;
  logic window_now;
  logic access;
  logic [close_onto_fault_logic_pkg::EV_WIDTH-1:0] ev_set;
  logic [close_onto_fault_logic_pkg::EV_WIDTH-1:0] ev_clr;
  logic [31:0] rd_data;

  always_comb begin
    s_next = s_reg;
    ev_set = '0;
    ev_clr = '0;
    rd_data = 32'h0000_0000;

    s_next.in_meta = {i_block, i_breaker_close_command,
                      i_fault_pickup_delayed, i_fault_pickup_now};
    s_next.in_sync = s_reg.in_meta;

    if (s_reg.tick_cnt == 15'(TICK_CYCLES - 1)) begin
      s_next.tick_cnt = 15'h0000;
      s_next.tick = 1'b1;
    end else begin
      s_next.tick_cnt = s_reg.tick_cnt + 15'h0001;
      s_next.tick = 1'b0;
    end

    enabled = s_reg.op == close_onto_fault_logic_pkg::OP_ENABLE;
    blocked = s_reg.in_sync[close_onto_fault_logic_pkg::IN_BLOCK];
    live = enabled && !blocked;
    close_cmd = s_reg.in_sync[close_onto_fault_logic_pkg::IN_CLOSE];
    pick_now = s_reg.in_sync[close_onto_fault_logic_pkg::IN_NOW];
    pick_dly = s_reg.in_sync[close_onto_fault_logic_pkg::IN_DLY];

    // Delay timer runs only while the delayed pickup is held
    tmr_run[close_onto_fault_logic_pkg::TMR_DLY] = live && pick_dly;
    tmr_clear[close_onto_fault_logic_pkg::TMR_DLY] = !live || !pick_dly;
    dly_ready = pick_dly && tmr_elapsed[close_onto_fault_logic_pkg::TMR_DLY];

    // Arm timer runs only in the hold phase after the close command
    tmr_run[close_onto_fault_logic_pkg::TMR_ARM] = s_reg.win == close_onto_fault_logic_pkg::WIN_HOLD;
    tmr_clear[close_onto_fault_logic_pkg::TMR_ARM] = !live || close_cmd ||
                                   s_reg.win != close_onto_fault_logic_pkg::WIN_HOLD;

    window_now = live && (close_cmd || (s_reg.win != close_onto_fault_logic_pkg::WIN_IDLE &&
                 !tmr_elapsed[close_onto_fault_logic_pkg::TMR_ARM]));

    unique case (s_reg.win)
      close_onto_fault_logic_pkg::WIN_IDLE: begin
        if (live && close_cmd) begin
          s_next.win = close_onto_fault_logic_pkg::WIN_CLOSE;
        end
      end
      close_onto_fault_logic_pkg::WIN_CLOSE: begin
        if (!live) begin
          s_next.win = close_onto_fault_logic_pkg::WIN_IDLE;
        end else if (!close_cmd) begin
          s_next.win = close_onto_fault_logic_pkg::WIN_HOLD;
        end
      end
      close_onto_fault_logic_pkg::WIN_HOLD: begin
        if (!live) begin
          s_next.win = close_onto_fault_logic_pkg::WIN_IDLE;
        end else if (close_cmd) begin
          s_next.win = close_onto_fault_logic_pkg::WIN_CLOSE;
        end else if (tmr_elapsed[close_onto_fault_logic_pkg::TMR_ARM]) begin
          s_next.win = close_onto_fault_logic_pkg::WIN_IDLE;
        end
      end
    endcase

    s_next.trip = window_now && (pick_now || dly_ready);

    // Events
    s_next.blk_prev = blocked;
    ev_set[close_onto_fault_logic_pkg::EV_TRIP] = s_next.trip && !s_reg.trip;
    ev_set[close_onto_fault_logic_pkg::EV_ARM] = live && close_cmd && s_reg.win == close_onto_fault_logic_pkg::WIN_IDLE;
    ev_set[close_onto_fault_logic_pkg::EV_BLOCK] = blocked && !s_reg.blk_prev;

    // APB: two-cycle access phase, writes take effect on the completing edge
    access = i_psel && i_penable;
    s_next.pready = access && !s_reg.pready;

    if (i_paddr == close_onto_fault_logic_pkg::ADDR_CTRL) begin
      rd_data[close_onto_fault_logic_pkg::CTRL_OP_LSB +: 3] = s_reg.op;
    end else if (i_paddr == close_onto_fault_logic_pkg::ADDR_ARM) begin
      rd_data[15:0] = s_reg.arm_set;
    end else if (i_paddr == close_onto_fault_logic_pkg::ADDR_DELAY) begin
      rd_data[15:0] = s_reg.dly_set;
    end else if (i_paddr == close_onto_fault_logic_pkg::ADDR_STATUS) begin
      rd_data[close_onto_fault_logic_pkg::EV_WIDTH-1:0] = s_reg.ev;
    end else if (i_paddr == close_onto_fault_logic_pkg::ADDR_MASK) begin
      rd_data[close_onto_fault_logic_pkg::EV_WIDTH-1:0] = s_reg.mask;
    end else if (i_paddr == close_onto_fault_logic_pkg::ADDR_STATE) begin
      rd_data[close_onto_fault_logic_pkg::STATE_CODE_LSB +: 3] = status_code(s_reg.op, blocked);
      rd_data[close_onto_fault_logic_pkg::STATE_WIN_BIT] = s_reg.win != close_onto_fault_logic_pkg::WIN_IDLE;
      rd_data[close_onto_fault_logic_pkg::STATE_TRIP_BIT] = s_reg.trip;
      rd_data[close_onto_fault_logic_pkg::STATE_IN_LSB +: 4] = s_reg.in_sync;
    end

    if (access && !s_reg.pready) begin
      s_next.prdata = i_pwrite ? 32'h0000_0000 : rd_data;
      s_next.pslverr = !addr_mapped(i_paddr);
    end else begin
      s_next.prdata = 32'h0000_0000;
      s_next.pslverr = 1'b0;
    end

    if (access && s_reg.pready && i_pwrite) begin
      if (i_paddr == close_onto_fault_logic_pkg::ADDR_CTRL) begin
        s_next.op = i_pwdata[close_onto_fault_logic_pkg::CTRL_OP_LSB +: 3];
      end else if (i_paddr == close_onto_fault_logic_pkg::ADDR_ARM) begin
        s_next.arm_set = clamp_setting(i_pwdata[15:0]);
      end else if (i_paddr == close_onto_fault_logic_pkg::ADDR_DELAY) begin
        s_next.dly_set = clamp_setting(i_pwdata[15:0]);
      end else if (i_paddr == close_onto_fault_logic_pkg::ADDR_STATUS) begin
        ev_clr = i_pwdata[close_onto_fault_logic_pkg::EV_WIDTH-1:0];
      end else if (i_paddr == close_onto_fault_logic_pkg::ADDR_MASK) begin
        s_next.mask = i_pwdata[close_onto_fault_logic_pkg::EV_WIDTH-1:0];
      end
    end

    // Set wins over a simultaneous write-one clear
    s_next.ev = (s_reg.ev & ~ev_clr) | ev_set;
    s_next.irq = |(s_next.ev & s_next.mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      s_reg <= '0;
      s_reg.win <= close_onto_fault_logic_pkg::WIN_IDLE;
      s_reg.op <= close_onto_fault_logic_pkg::OP_ENABLE;
      s_reg.arm_set <= close_onto_fault_logic_pkg::ARM_DEFAULT;
      s_reg.dly_set <= close_onto_fault_logic_pkg::DELAY_DEFAULT;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_fault_clear_out = s_reg.trip;
  assign o_prdata = s_reg.prdata;
  assign o_pready = s_reg.pready;
  assign o_pslverr = s_reg.pslverr;
  assign o_irq = s_reg.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_disabled_quiet;
    @(posedge i_clk_sys) disable iff (!i_rstn)
      s_reg.op != close_onto_fault_logic_pkg::OP_ENABLE |=> !o_fault_clear_out && s_reg.win == close_onto_fault_logic_pkg::WIN_IDLE;
  endproperty
  a_disabled_quiet:
    assert property (p_disabled_quiet) else $error("trip or window while disabled");

  property p_close_arms;
    @(posedge i_clk_sys) disable iff (!i_rstn)
      live && close_cmd |=> s_reg.win == close_onto_fault_logic_pkg::WIN_CLOSE;
  endproperty
  a_close_arms:
    assert property (p_close_arms) else $error("close command did not open window");

  property p_window_holds;
    @(posedge i_clk_sys) disable iff (!i_rstn)
      live && s_reg.win == close_onto_fault_logic_pkg::WIN_HOLD && !close_cmd &&
      tmr_count[close_onto_fault_logic_pkg::TMR_ARM] < s_reg.arm_set |=> s_reg.win == close_onto_fault_logic_pkg::WIN_HOLD;
  endproperty
  a_window_holds:
    assert property (p_window_holds) else $error("window closed before arm time");

  property p_window_drops;
    @(posedge i_clk_sys) disable iff (!i_rstn)
      s_reg.win == close_onto_fault_logic_pkg::WIN_HOLD && !close_cmd &&
      tmr_count[close_onto_fault_logic_pkg::TMR_ARM] >= s_reg.arm_set |=> s_reg.win == close_onto_fault_logic_pkg::WIN_IDLE;
  endproperty
  a_window_drops:
    assert property (p_window_drops) else $error("window stayed open past arm time");

  property p_setting_range;
    @(posedge i_clk_sys) disable iff (!i_rstn)
      s_reg.arm_set <= close_onto_fault_logic_pkg::SETTING_MAX && s_reg.dly_set <= close_onto_fault_logic_pkg::SETTING_MAX;
  endproperty
  a_setting_range:
    assert property (p_setting_range) else $error("setting above 60000 ms");

  property p_trip_cause;
    @(posedge i_clk_sys) disable iff (!i_rstn)
      $rose(o_fault_clear_out) |-> $past(window_now) && ($past(pick_now) || $past(dly_ready));
  endproperty
  a_trip_cause:
    assert property (p_trip_cause) else $error("trip without window and fault");

  property p_trip_now;
    @(posedge i_clk_sys) disable iff (!i_rstn)
      live && close_cmd && pick_now |=> o_fault_clear_out;
  endproperty
  a_trip_now:
    assert property (p_trip_now) else $error("immediate pickup did not trip at once");

  property p_delay_gate;
    @(posedge i_clk_sys) disable iff (!i_rstn)
      dly_ready && s_reg.dly_set != 16'h0000 |-> tmr_count[close_onto_fault_logic_pkg::TMR_DLY] >= s_reg.dly_set;
  endproperty
  a_delay_gate:
    assert property (p_delay_gate) else $error("delayed pickup passed early");

  property p_block_clears;
    @(posedge i_clk_sys) disable iff (!i_rstn)
      blocked |=> !o_fault_clear_out && tmr_count[close_onto_fault_logic_pkg::TMR_DLY] == 16'h0000 &&
                  tmr_count[close_onto_fault_logic_pkg::TMR_ARM] == 16'h0000;
  endproperty
  a_block_clears:
    assert property (p_block_clears) else $error("block left output or timer active");

  property p_tick_period;
    @(posedge i_clk_sys) disable iff (!i_rstn)
      s_reg.tick |=> !s_reg.tick && s_reg.tick_cnt == 15'h0001;
  endproperty
  a_tick_period:
    assert property (p_tick_period) else $error("ms tick out of step");

  property p_restart;
    @(posedge i_clk_sys) disable iff (!i_rstn)
      !pick_dly |=> tmr_count[close_onto_fault_logic_pkg::TMR_DLY] == 16'h0000;
  endproperty
  a_restart:
    assert property (p_restart) else $error("delay timer not cleared on drop");

endmodule

// ---- bench/close_onto_fault_logic_far_model.sv ----
// Far-side model: upstream pickups, close command source and block pin.
// Assumes the bench moves one pin per call, right after a rising edge.
`timescale 1ns/1ps
module close_onto_fault_logic_far_model (
  // Clock
  input wire logic i_clk_sys,
  // Pins toward the block
  output logic o_pickup_now,
  output logic o_pickup_delayed,
  output logic o_close_command,
  output logic o_block
);
  // All pins start false
  logic [3:0] pins_reg = 4'h0;
  // High-set, low-set, close and block on their own pins
  assign o_pickup_now = pins_reg[close_onto_fault_logic_pkg::IN_NOW];
  assign o_pickup_delayed = pins_reg[close_onto_fault_logic_pkg::IN_DLY];
  assign o_close_command = pins_reg[close_onto_fault_logic_pkg::IN_CLOSE];
  assign o_block = pins_reg[close_onto_fault_logic_pkg::IN_BLOCK];
  ////////////////////////////////////////////////////////////////////////////////
  task automatic drive(input int unsigned idx, input logic val);
    @(posedge i_clk_sys);
    pins_reg[idx] <= val;
  endtask
endmodule

// ---- bench/close_onto_fault_logic_bench.sv ----
// Self-checking bench of the close-onto-fault trip logic.
// Assumes a 1 ms tick of 20 cycles and the far-side pin model.
`timescale 1ns/1ps
module close_onto_fault_logic_bench;
  localparam int unsigned MS = 20;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq, trip, now, dly, close, blk;
  logic [31:0] rd;
  logic er;
  int err_count = 0;
  int comparisons = 0;

  always #25 clk_sys = ~clk_sys;

  close_onto_fault_logic_far_model i_close_onto_fault_logic_far_model (.i_clk_sys(clk_sys), .o_pickup_now(now),
    .o_pickup_delayed(dly), .o_close_command(close), .o_block(blk));
  close_onto_fault_logic #(.TICK_CYCLES(MS)) i_close_onto_fault_logic (
    .i_clk_sys(clk_sys), .i_rstn(rstn), .i_fault_pickup_now(now),
    .i_fault_pickup_delayed(dly), .i_breaker_close_command(close), .i_block(blk),
    .o_fault_clear_out(trip), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_irq(irq));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string msg);
    chk_word({31'h0, got}, {31'h0, exp}, msg);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
    int unsigned n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    // Sample the answer at the rising edge itself, release only then
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk_word(n, 32'h2, "bus answer cycles");
    // Let registered results settle before callers look at them
    @(negedge clk_sys);
  endtask

  task automatic wr(input logic [11:0] addr, input logic [31:0] wd);
    apb(1'b1, addr, wd);
  endtask

  task automatic rdm(input logic [11:0] addr, input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0);
    chk_word(rd & m, exp, "register read");
  endtask

  task automatic pin(input int unsigned idx, input logic v);
    i_close_onto_fault_logic_far_model.drive(idx, v);
  endtask

  task automatic wait_trip(input logic exp, input int unsigned max_cyc, input string msg);
    int unsigned n;
    n = 0;
    @(negedge clk_sys);
    while (trip !== exp && n < max_cyc) begin
      @(negedge clk_sys);
      n++;
    end
    chk_bit(trip, exp, msg);
  endtask

  task automatic hold_trip(input logic exp, input int unsigned cyc, input string msg);
    logic bad;
    bad = 1'b0;
    repeat (cyc) begin
      @(negedge clk_sys);
      if (trip !== exp) bad = 1'b1;
    end
    chk_bit(bad, 1'b0, msg);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    chk_bit(trip, 1'b0, "trip after reset");
    rdm(close_onto_fault_logic_pkg::ADDR_CTRL, 32'h7, 32'h1);
    rdm(close_onto_fault_logic_pkg::ADDR_ARM, 32'hFFFF, 32'h3E8);
    rdm(close_onto_fault_logic_pkg::ADDR_DELAY, 32'hFFFF, 32'h0);
    rdm(close_onto_fault_logic_pkg::ADDR_STATE, 32'hFFFFFFFF, 32'h1);
    rdm(12'h018, 32'hFFFFFFFF, 32'h0);
    chk_bit(er, 1'b1, "unmapped error");
    wr(close_onto_fault_logic_pkg::ADDR_ARM, 32'hFFFF);
    rdm(close_onto_fault_logic_pkg::ADDR_ARM, 32'hFFFF, 32'hEA60);
    wr(close_onto_fault_logic_pkg::ADDR_DELAY, 32'hEA61);
    rdm(close_onto_fault_logic_pkg::ADDR_DELAY, 32'hFFFF, 32'hEA60);
    wr(close_onto_fault_logic_pkg::ADDR_ARM, 32'h3);
    wr(close_onto_fault_logic_pkg::ADDR_DELAY, 32'h0);
    $display("reset and settings test done");
  endtask

  task automatic test_now();
    pin(close_onto_fault_logic_pkg::IN_NOW, 1'b1);
    hold_trip(1'b0, 10, "trip without window");
    pin(close_onto_fault_logic_pkg::IN_CLOSE, 1'b1);
    wait_trip(1'b1, 4, "immediate trip");
    rdm(close_onto_fault_logic_pkg::ADDR_STATUS, 32'h7, 32'h3);
    chk_bit(irq, 1'b0, "irq masked");
    wr(close_onto_fault_logic_pkg::ADDR_MASK, 32'h1);
    chk_bit(irq, 1'b1, "irq raised");
    wr(close_onto_fault_logic_pkg::ADDR_STATUS, 32'h3);
    chk_bit(irq, 1'b0, "irq cleared");
    $display("immediate trip test done");
  endtask

  task automatic test_hold();
    pin(close_onto_fault_logic_pkg::IN_NOW, 1'b0);
    wait_trip(1'b0, 4, "trip drops");
    pin(close_onto_fault_logic_pkg::IN_CLOSE, 1'b0);
    repeat (20) @(posedge clk_sys);
    rdm(close_onto_fault_logic_pkg::ADDR_STATE, 32'h10, 32'h10);
    repeat (60) @(posedge clk_sys);
    rdm(close_onto_fault_logic_pkg::ADDR_STATE, 32'h10, 32'h0);
    pin(close_onto_fault_logic_pkg::IN_NOW, 1'b1);
    hold_trip(1'b0, 10, "trip after window");
    pin(close_onto_fault_logic_pkg::IN_NOW, 1'b0);
    $display("window hold test done");
  endtask

  task automatic test_delay();
    wr(close_onto_fault_logic_pkg::ADDR_DELAY, 32'h4);
    pin(close_onto_fault_logic_pkg::IN_CLOSE, 1'b1);
    pin(close_onto_fault_logic_pkg::IN_DLY, 1'b1);
    hold_trip(1'b0, 50, "delayed too early");
    pin(close_onto_fault_logic_pkg::IN_DLY, 1'b0);
    repeat (5) @(posedge clk_sys);
    pin(close_onto_fault_logic_pkg::IN_DLY, 1'b1);
    hold_trip(1'b0, 50, "delay restart");
    wait_trip(1'b1, 40, "delayed trip");
    $display("delayed trip test done");
  endtask

  task automatic test_block();
    pin(close_onto_fault_logic_pkg::IN_BLOCK, 1'b1);
    wait_trip(1'b0, 4, "block trip");
    rdm(close_onto_fault_logic_pkg::ADDR_STATE, 32'h17, 32'h2);
    rdm(close_onto_fault_logic_pkg::ADDR_STATUS, 32'h4, 32'h4);
    wr(close_onto_fault_logic_pkg::ADDR_STATUS, 32'h7);
    pin(close_onto_fault_logic_pkg::IN_BLOCK, 1'b0);
    hold_trip(1'b0, 30, "timers after block");
    pin(close_onto_fault_logic_pkg::IN_DLY, 1'b0);
    pin(close_onto_fault_logic_pkg::IN_CLOSE, 1'b0);
    $display("block test done");
  endtask

  task automatic test_disable();
    wr(close_onto_fault_logic_pkg::ADDR_CTRL, 32'h5);
    pin(close_onto_fault_logic_pkg::IN_CLOSE, 1'b1);
    pin(close_onto_fault_logic_pkg::IN_NOW, 1'b1);
    hold_trip(1'b0, 10, "disabled trip");
    rdm(close_onto_fault_logic_pkg::ADDR_STATE, 32'h7, 32'h5);
    wr(close_onto_fault_logic_pkg::ADDR_CTRL, 32'h1);
    wait_trip(1'b1, 4, "trip on enable");
    pin(close_onto_fault_logic_pkg::IN_CLOSE, 1'b0);
    repeat (3) @(posedge clk_sys);
    pin(close_onto_fault_logic_pkg::IN_CLOSE, 1'b1);
    wait_trip(1'b1, 8, "enabled trip");
    pin(close_onto_fault_logic_pkg::IN_NOW, 1'b0);
    pin(close_onto_fault_logic_pkg::IN_CLOSE, 1'b0);
    $display("operation code test done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    final_report();
  end

  initial begin
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    test_reset();
    test_now();
    test_hold();
    test_delay();
    test_block();
    test_disable();
    final_report();
  end
endmodule
